// ===== logic/cps_regs.svh
/*
  register offsets, bit positions, reset values, ip increment and interrupt vector for the core
  sequencing block. assumes it is included by its bare name.
*/
`ifndef CPS_REGS_SVH
`define CPS_REGS_SVH

// software port map
`define CPS_ADDR_DEREF   8'h00
`define CPS_ADDR_IPLOW   8'h02
`define CPS_ADDR_STATUS  8'h03
`define CPS_ADDR_POINTER 8'h04
`define CPS_ADDR_IPHOLD  8'h0A

// status bit positions
`define CPS_ST_MSB  0
`define CPS_ST_NIB  1
`define CPS_ST_ZERO 2
`define CPS_ST_PD   3
`define CPS_ST_TO   4
`define CPS_ST_BANK_HI 7
`define CPS_ST_BANK_LO 5

// holding register field positions
`define CPS_HOLD_TOP 4
`define CPS_HOLD_JMP 3

// reset values, ip increment and interrupt vector
`define CPS_IP_RST     13'h0000
`define CPS_HOLD_RST   5'h00
`define CPS_PTR_RST    8'h00
`define CPS_BANK_RST   3'h0
`define CPS_TO_RST     1'b1
`define CPS_PD_RST     1'b1
`define CPS_FLAG_RST   1'b0
`define CPS_ZERO_BYTE  8'h00
`define CPS_ONE_IP     13'h0001
`define CPS_VEC_IP     13'h0004

`endif

// ===== logic/cps_pkg.sv
/*
  types shared by the core sequencing block: ALU and control operations.
  assumes nothing of its surroundings.
*/
package cps_pkg;
  typedef enum logic [3:0] {
    CPS_OP_NONE,
    CPS_OP_ADD,
    CPS_OP_SUB,
    CPS_OP_LOGIC,
    CPS_OP_ROR,
    CPS_OP_ROL,
    CPS_OP_KICK,
    CPS_OP_SLEEP,
    CPS_OP_WDT_TIMEOUT
  } cps_op_t;

  typedef enum logic [2:0] {
    CPS_FLOW_STEP,
    CPS_FLOW_JUMP,
    CPS_FLOW_CALL,
    CPS_FLOW_RETURN,
    CPS_FLOW_IRQ,
    CPS_FLOW_HOLD
  } cps_flow_t;
endpackage

// ===== logic/cps_core.sv
/*
  status flags, program counter, circular return stack and pointer
  indirection of a small 8-bit core. assumes instruction decode drives
  the op, flow and data inputs one cycle per instruction, and that the
  data memory outside answers the effective address combinationally.
*/
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "cps_regs.svh"

module cps_core #(
  parameter int IP_W = 13,
  parameter int DEPTH = 8,
  parameter int TGT_W = 11
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire cps_pkg::cps_op_t i_op,
  input wire cps_pkg::cps_flow_t i_flow,
  input wire logic [7:0] i_opa,
  input wire logic [7:0] i_opb,
  input wire logic [TGT_W-1:0] i_target,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_mem_rdata,
  output logic [7:0] o_rdata,
  output logic [7:0] o_alu_result,
  output logic [IP_W-1:0] o_ip,
  output logic [8:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_mem_wr
);
  import cps_pkg::*;

  localparam int PW = $clog2(DEPTH);

  logic [7:0] status_v;
  logic [2:0] bank_q;
  logic to_q;
  logic pd_q;
  logic zero_q;
  logic nib_q;
  logic msb_q;
  logic status_wr;
  logic iplow_wr;
  logic hold_wr;
  logic ptr_wr;
  logic zero_op;
  logic push;
  logic pop;
  logic [IP_W-1:0] ip_q;
  logic [IP_W-1:0] ip_d;
  logic [4:0] hold_q;
  logic [7:0] ptr_q;
  logic [IP_W-1:0] stack_q [DEPTH];
  logic [PW-1:0] sp_q;
  logic [7:0] res;
  logic nib_c;
  logic msb_c;
  logic flag_op;
  logic deref;
  logic self_ref;

  // subtraction is a + ~b + 1, so carries read as inverted borrow
  function automatic logic [8:0] add_c(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
    add_c = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction

  function automatic logic [4:0] nib_add(input logic [3:0] a, input logic [3:0] b,
                                         input logic cin);
    nib_add = {1'b0, a} + {1'b0, b} + {4'h0, cin};
  endfunction

  // write decode shared by every register that software can load
  function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
                                  input logic [7:0] target);
    wr_hit = wr && (addr == target);
  endfunction

  assign status_wr = wr_hit(i_wr, i_addr, `CPS_ADDR_STATUS);
  assign iplow_wr = wr_hit(i_wr, i_addr, `CPS_ADDR_IPLOW);
  assign hold_wr = wr_hit(i_wr, i_addr, `CPS_ADDR_IPHOLD);
  assign ptr_wr = wr_hit(i_wr, i_addr, `CPS_ADDR_POINTER);

  // rotates leave the zero flag alone, only these ops judge the result
  assign zero_op = (i_op == CPS_OP_ADD) || (i_op == CPS_OP_SUB) || (i_op == CPS_OP_LOGIC);

  // push and pop are actions of the flow code, never explicit operations
  assign push = (i_flow == CPS_FLOW_CALL) || (i_flow == CPS_FLOW_IRQ);
  assign pop = (i_flow == CPS_FLOW_RETURN);

  // status is assembled from its per-bit owners; each bit has one writer
  assign status_v = {bank_q, to_q, pd_q, zero_q, nib_q, msb_q};

  always_comb begin
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] opb_x;
    logic cin;
    sum = 9'h000;
    nib = 5'h00;
    cin = (i_op == CPS_OP_SUB);
    opb_x = cin ? ~i_opb : i_opb;
    res = i_opa;
    nib_c = nib_q;
    msb_c = msb_q;
    flag_op = 1'b1;
    case (i_op)
      CPS_OP_ADD, CPS_OP_SUB: begin
        sum = add_c(i_opa, opb_x, cin);
        nib = nib_add(i_opa[3:0], opb_x[3:0], cin);
        res = sum[7:0];
        nib_c = nib[4];
        msb_c = sum[8];
      end
      CPS_OP_LOGIC: begin
        res = i_opa;
      end
      CPS_OP_ROR: begin
        res = {msb_q, i_opa[7:1]};
        msb_c = i_opa[0];
      end
      CPS_OP_ROL: begin
        res = {i_opa[6:0], msb_q};
        msb_c = i_opa[7];
      end
      default: begin
        flag_op = 1'b0;
      end
    endcase
  end

  assign deref = (i_addr == `CPS_ADDR_DEREF);
  assign self_ref = deref && (ptr_q == `CPS_ADDR_DEREF);

  // bank selects are plain storage; nothing in this block decodes them
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      bank_q <= `CPS_BANK_RST;
    end else if (status_wr) begin
      bank_q <= i_wdata[`CPS_ST_BANK_HI:`CPS_ST_BANK_LO];
    end
  end

  // expiry flag: only operations move it, software writes never reach it
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      to_q <= `CPS_TO_RST;
    end else begin
      case (i_op)
        CPS_OP_KICK, CPS_OP_SLEEP: begin
          to_q <= 1'b1;
        end
        CPS_OP_WDT_TIMEOUT: begin
          to_q <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // power-down flag: reset stands in for power-up
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pd_q <= `CPS_PD_RST;
    end else begin
      case (i_op)
        CPS_OP_KICK: begin
          pd_q <= 1'b1;
        end
        CPS_OP_SLEEP: begin
          pd_q <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // a flag op in the same cycle as a status write wins over the write
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      zero_q <= `CPS_FLAG_RST;
    end else if (zero_op) begin
      zero_q <= (res == `CPS_ZERO_BYTE);
    end else if (status_wr && !flag_op) begin
      zero_q <= i_wdata[`CPS_ST_ZERO];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      nib_q <= `CPS_FLAG_RST;
    end else if (flag_op) begin
      nib_q <= nib_c;
    end else if (status_wr) begin
      nib_q <= i_wdata[`CPS_ST_NIB];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      msb_q <= `CPS_FLAG_RST;
    end else if (flag_op) begin
      msb_q <= msb_c;
    end else if (status_wr) begin
      msb_q <= i_wdata[`CPS_ST_MSB];
    end
  end

  // the stack never touches the holding register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_q <= `CPS_HOLD_RST;
    end else if (hold_wr) begin
      hold_q <= i_wdata[`CPS_HOLD_TOP:0];
    end
  end

  // the pointer is free for software; indirection reads it every cycle
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ptr_q <= `CPS_PTR_RST;
    end else if (ptr_wr) begin
      ptr_q <= i_wdata;
    end
  end

  // next pointer; a low-byte write loads the upper bits from the holding register
  always_comb begin
    ip_d = ip_q + `CPS_ONE_IP;
    case (i_flow)
      CPS_FLOW_JUMP, CPS_FLOW_CALL: begin
        ip_d = {hold_q[`CPS_HOLD_TOP:`CPS_HOLD_JMP], i_target};
      end
      CPS_FLOW_RETURN: begin
        ip_d = stack_q[sp_q - PW'(1)];
      end
      CPS_FLOW_IRQ: begin
        ip_d = `CPS_VEC_IP;
      end
      CPS_FLOW_HOLD: begin
        ip_d = ip_q;
      end
      default: begin
      end
    endcase
    // a low-byte write outranks the flow code of the same cycle
    if (iplow_wr) begin
      ip_d = {hold_q, i_wdata};
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ip_q <= `CPS_IP_RST;
    end else begin
      ip_q <= ip_d;
    end
  end

  // circular stack: pointer wraps silently, no overflow flag
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sp_q <= '0;
    end else if (push) begin
      sp_q <= sp_q + PW'(1);
    end else if (pop) begin
      sp_q <= sp_q - PW'(1);
    end
  end

  // return address is the instruction after the call, or the interrupted one
  always_ff @(posedge i_sys_clk) begin
    if (i_flow == CPS_FLOW_CALL) begin
      stack_q[sp_q] <= ip_q + `CPS_ONE_IP;
    end else if (i_flow == CPS_FLOW_IRQ) begin
      stack_q[sp_q] <= ip_q;
    end
  end

  // software read port, data one cycle after the strobe
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= `CPS_ZERO_BYTE;
    end else if (i_rd) begin
      case (i_addr)
        `CPS_ADDR_DEREF: o_rdata <= self_ref ? `CPS_ZERO_BYTE : i_mem_rdata;
        `CPS_ADDR_IPLOW: o_rdata <= ip_q[7:0];
        `CPS_ADDR_STATUS: o_rdata <= status_v;
        `CPS_ADDR_POINTER: o_rdata <= ptr_q;
        `CPS_ADDR_IPHOLD: o_rdata <= {3'h0, hold_q};
        default: o_rdata <= i_mem_rdata;
      endcase
    end else begin
      o_rdata <= `CPS_ZERO_BYTE;
    end
  end

  // memory side: indirect accesses carry the pointer, bank bit forced zero
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mem_addr <= 9'h000;
      o_mem_wdata <= `CPS_ZERO_BYTE;
      o_mem_wr <= 1'b0;
      o_alu_result <= `CPS_ZERO_BYTE;
      o_ip <= `CPS_IP_RST;
    end else begin
      o_mem_addr <= deref ? {1'b0, ptr_q} : {1'b0, i_addr};
      o_mem_wdata <= i_wdata;
      o_mem_wr <= i_wr && !self_ref;
      o_alu_result <= res;
      o_ip <= ip_d;
    end
  end
endmodule

// ===== tb/cps_core_chk.sv
/* port checks for cps_core.
   assumes it is bound to cps_core and sees only that module's ports. */
`timescale 1ns/1ps
`include "cps_regs.svh"
module cps_core_chk #(
  parameter int IP_W = 13,
  parameter int TGT_W = 11
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire cps_pkg::cps_flow_t i_flow,
  input wire logic [TGT_W-1:0] i_target,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic [IP_W-1:0] o_ip,
  input wire logic [8:0] o_mem_addr,
  input wire logic [7:0] o_mem_wdata,
  input wire logic o_mem_wr
);
  import cps_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  bank_zero_a: assert property (o_mem_addr[8] == 1'b0)
    else $error("bank bit set");
  rst_clear_a: assert property ($fell(i_rst) |-> o_ip == `CPS_IP_RST)
    else $error("ip not cleared");
  step_inc_a: assert property (i_flow == CPS_FLOW_STEP && !i_wr |=>
    o_ip == $past(o_ip) + 1'b1) else $error("ip step");
  hold_ip_a: assert property (i_flow == CPS_FLOW_HOLD && !i_wr |=> $stable(o_ip))
    else $error("ip moved");
  jump_low_a: assert property (i_flow inside {CPS_FLOW_JUMP, CPS_FLOW_CALL} |=>
    o_ip[TGT_W-1:0] == $past(i_target)) else $error("jump target");
  irq_vec_a: assert property (i_flow == CPS_FLOW_IRQ |=> o_ip == `CPS_VEC_IP)
    else $error("irq vector");
  low_wr_a: assert property (i_wr && i_addr == `CPS_ADDR_IPLOW &&
    i_flow == CPS_FLOW_HOLD |=> o_ip[7:0] == $past(i_wdata)) else $error("low byte");
  mem_wr_a: assert property (o_mem_wr |-> $past(i_wr) &&
    o_mem_wdata == $past(i_wdata)) else $error("mem write");
endmodule

// ===== tb/tb_cps_core.sv
/* directed bench for cps_core: flags, ip loading, stack, indirection.
   assumes cps_pkg and cps_regs.svh are compiled ahead of it. */
`timescale 1ns/1ps
`include "cps_regs.svh"
module tb_cps_core;
  import cps_pkg::*;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  cps_op_t i_op = CPS_OP_NONE;
  cps_flow_t i_flow = CPS_FLOW_HOLD;
  logic [7:0] i_opa = 8'h00, i_opb = 8'h00, i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00, i_mem_rdata = 8'h00;
  logic [10:0] i_target = 11'h000;
  logic [7:0] o_rdata, o_alu_result, o_mem_wdata;
  logic [12:0] o_ip;
  logic [8:0] o_mem_addr;
  logic o_mem_wr;
  int errors = 0;
  int compares = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  cps_core i_cps_core (.i_sys_clk, .i_rst, .i_op, .i_flow, .i_opa, .i_opb, .i_target,
    .i_addr, .i_wdata, .i_wr, .i_rd, .i_mem_rdata, .o_rdata, .o_alu_result, .o_ip,
    .o_mem_addr, .o_mem_wdata, .o_mem_wr);
  // outputs are read in the active region of the next edge, before its updates land
  task st;
    @(posedge i_sys_clk);
  endtask
  task chk(input logic [17:0] g, input logic [17:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    st;
    i_wr <= 1'b0;
    st;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    i_rd <= 1'b1;
    i_addr <= a;
    st;
    i_rd <= 1'b0;
    st;
    chk(o_rdata & m, e);
  endtask
  task al(input cps_op_t op, input logic [7:0] a, b, e, m);
    i_op <= op;
    i_opa <= a;
    i_opb <= b;
    st;
    i_op <= CPS_OP_NONE;
    rdc(`CPS_ADDR_STATUS, e, m);
  endtask
  task fl(input cps_flow_t f, input logic [10:0] t, input logic [12:0] e);
    i_flow <= f;
    i_target <= t;
    st;
    i_flow <= CPS_FLOW_HOLD;
    st;
    chk(o_ip, e);
  endtask
  task t_status;
    rdc(`CPS_ADDR_STATUS, 8'h18, 8'hFF);
    wr(`CPS_ADDR_STATUS, 8'h05);
    rdc(`CPS_ADDR_STATUS, 8'h1D, 8'hFF);
    al(CPS_OP_WDT_TIMEOUT, 8'h00, 8'h00, 8'h08, 8'h18);
    al(CPS_OP_SLEEP, 8'h00, 8'h00, 8'h10, 8'h18);
    al(CPS_OP_KICK, 8'h00, 8'h00, 8'h18, 8'h18);
    $display("status test done");
  endtask
  task t_alu;
    al(CPS_OP_ADD, 8'h0F, 8'h01, 8'h02, 8'h07);
    al(CPS_OP_ADD, 8'hFF, 8'h01, 8'h07, 8'h07);
    al(CPS_OP_SUB, 8'h05, 8'h05, 8'h07, 8'h07);
    al(CPS_OP_SUB, 8'h03, 8'h05, 8'h00, 8'h07);
    al(CPS_OP_ROR, 8'h01, 8'h00, 8'h01, 8'h01);
    al(CPS_OP_ROL, 8'h7F, 8'h00, 8'h00, 8'h01);
    i_op <= CPS_OP_SUB;
    i_opa <= 8'h03;
    i_opb <= 8'h05;
    st;
    i_op <= CPS_OP_NONE;
    st;
    chk(o_alu_result, 8'hFE);
    i_op <= CPS_OP_ADD;
    i_opa <= 8'hFF;
    i_opb <= 8'h01;
    wr(`CPS_ADDR_STATUS, 8'h00);
    i_op <= CPS_OP_NONE;
    rdc(`CPS_ADDR_STATUS, 8'h07, 8'h07);
    $display("alu test done");
  endtask
  task t_ip;
    wr(`CPS_ADDR_IPHOLD, 8'h15);
    wr(`CPS_ADDR_IPLOW, 8'h34);
    chk(o_ip, 13'h1534);
    rdc(`CPS_ADDR_IPLOW, 8'h34, 8'hFF);
    fl(CPS_FLOW_JUMP, 11'h7FF, 13'h17FF);
    fl(CPS_FLOW_STEP, 11'h000, 13'h1800);
    fl(CPS_FLOW_IRQ, 11'h000, `CPS_VEC_IP);
    fl(CPS_FLOW_RETURN, 11'h000, 13'h1800);
    // nine calls: the ninth lands on the first slot
    for (int k = 1; k < 10; k++) fl(CPS_FLOW_CALL, 11'(k), 13'h1000 + 13'(k));
    for (int k = 9; k > 1; k--) fl(CPS_FLOW_RETURN, 11'h000, 13'h1000 + 13'(k));
    fl(CPS_FLOW_RETURN, 11'h000, 13'h1009);
    wr(`CPS_ADDR_IPLOW, 8'h00);
    chk(o_ip, 13'h1500);
    $display("ip test done");
  endtask
  task t_ind;
    wr(`CPS_ADDR_POINTER, 8'h25);
    wr(`CPS_ADDR_DEREF, 8'h5A);
    chk({o_mem_wr, o_mem_addr, o_mem_wdata}, {1'b1, 9'h025, 8'h5A});
    i_mem_rdata <= 8'hC3;
    rdc(`CPS_ADDR_DEREF, 8'hC3, 8'hFF);
    rdc(8'h40, 8'hC3, 8'hFF);
    wr(`CPS_ADDR_POINTER, 8'h00);
    wr(`CPS_ADDR_DEREF, 8'h5A);
    chk(o_mem_wr, 1'b0);
    rdc(`CPS_ADDR_DEREF, 8'h00, 8'hFF);
    $display("pointer test done");
  endtask
  task t_rst;
    i_rst <= 1'b1;
    st;
    chk(o_ip, `CPS_IP_RST);
    i_rst <= 1'b0;
    rdc(`CPS_ADDR_STATUS, 8'h18, 8'h18);
    $display("reset test done");
  endtask
  task close_out;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // tests take about 125 cycles; this allows ten thousand
  initial begin
    #100000;
    errors++;
    close_out;
  end
  initial begin
    repeat (16) st;
    i_rst <= 1'b0;
    t_status;
    t_alu;
    t_ip;
    t_ind;
    t_rst;
    close_out;
  end
endmodule
bind cps_core cps_core_chk #(.IP_W(IP_W), .TGT_W(TGT_W)) i_cps_core_chk (.i_sys_clk,
  .i_rst, .i_flow, .i_target, .i_addr, .i_wdata, .i_wr, .o_ip, .o_mem_addr,
  .o_mem_wdata, .o_mem_wr);
